// ### icx_exec.sv
// execution of the indirect call and register clear instructions
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - opcode 0014h decodes as indirect call
// - call pushes pc plus two first
// - then load pc from working register, latches
// - call takes two cycles, second is nop
// - call leaves flags, working register, bank alone
// - clear writes zero and sets zero flag
// - access bit picks access bank or bank select
// - extended set, a=0, f<=5Fh uses indexed offset
module icx_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] pc_current,
    input wire logic [7:0] working_register,
    input wire logic [7:0] pc_high_latch,
    input wire logic [4:0] pc_upper_latch,
    input wire logic [5:0] bank_select_register,
    input wire logic [13:0] index_base,
    output logic exec_nop,
    output icx_pkg::icx_phase_t quarter_phase,
    output icx_pkg::icx_push_t stack_push,
    output icx_pkg::icx_pcload_t pc_load,
    output icx_pkg::icx_fwr_t file_write,
    output logic zero_set,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    icx_pkg::icx_state_t st;
    icx_pkg::icx_state_t nx;
    logic take;
    logic call_take;
    logic clr_take;

    // ------------------------------------------------------------
    // data address of a clear operand
    // ------------------------------------------------------------
    function automatic logic [13:0] clr_address(
        input logic access_sel,
        input logic [7:0] f,
        input logic ext_en,
        input logic [5:0] bank,
        input logic [13:0] base
    );
        logic [13:0] addr;
        addr = {icx_pkg::ACCESS_LOW_BANK, f};
        if (access_sel) begin
            addr = {bank, f};
        end else if (ext_en && (f <= icx_pkg::IDX_OFFSET_LIMIT)) begin
            addr = 14'(base + {6'h00, f});
        end else if (f > icx_pkg::IDX_OFFSET_LIMIT) begin
            addr = {icx_pkg::ACCESS_HIGH_BANK, f};
        end
        return addr;
    endfunction : clr_address

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign take = (st.phase == icx_pkg::PH_Q1) && instr_valid && !st.nop_cycle;
    assign call_take = take && (instr_word == icx_pkg::OPC_CALL_VIA_WORKING_REGISTER);
    assign clr_take = take && (instr_word[15:9] == icx_pkg::OPC_CLEAR_FILE_HI);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nx = st;
        nx.push.valid = 1'b0;
        nx.pcload.valid = 1'b0;
        nx.fwr.valid = 1'b0;
        nx.zero_set = 1'b0;
        unique case (st.phase)
            icx_pkg::PH_Q1: begin
                nx.phase = icx_pkg::PH_Q2;
                nx.op = icx_pkg::OP_NONE;
                nx.operand = instr_word[7:0];
                nx.access_sel = instr_word[icx_pkg::CLR_ACCESS_BIT];
                nx.pc_cap = pc_current;
                if (call_take) begin
                    nx.op = icx_pkg::OP_CALL;
                end else if (clr_take) begin
                    nx.op = icx_pkg::OP_CLEAR;
                end
            end
            icx_pkg::PH_Q2: begin
                nx.phase = icx_pkg::PH_Q3;
                nx.working_register_cap = working_register;
                nx.clr_addr = clr_address(st.access_sel, st.operand, st.ext_en,
                    bank_select_register, index_base);
            end
            icx_pkg::PH_Q3: begin
                nx.phase = icx_pkg::PH_Q4;
                if (st.op == icx_pkg::OP_CALL) begin
                    nx.push.valid = 1'b1;
                    nx.push.addr = 21'(st.pc_cap + icx_pkg::PC_STEP);
                end
            end
            icx_pkg::PH_Q4: begin
                nx.phase = icx_pkg::PH_Q1;
                nx.op = icx_pkg::OP_NONE;
                if (st.nop_cycle) begin
                    nx.nop_cycle = 1'b0;
                end else if (st.op == icx_pkg::OP_CALL) begin
                    // call drives no flag or file write
                    nx.pcload.valid = 1'b1;
                    nx.pcload.pc = {pc_upper_latch, pc_high_latch, st.working_register_cap};
                    nx.nop_cycle = 1'b1;
                    nx.last_call = 1'b1;
                    nx.last_clear = 1'b0;
                    nx.call_count = 16'(st.call_count + 16'h0001);
                end else if (st.op == icx_pkg::OP_CLEAR) begin
                    nx.fwr.valid = 1'b1;
                    nx.fwr.addr = st.clr_addr;
                    nx.fwr.data = icx_pkg::CLEAR_VALUE;
                    nx.zero_set = 1'b1;
                    nx.last_call = 1'b0;
                    nx.last_clear = 1'b1;
                    nx.clear_count = 16'(st.clear_count + 16'h0001);
                end
            end
        endcase

        // register bus: write side
        if (s_axi_awvalid && s_axi_awready) begin
            nx.aw_got = 1'b1;
            nx.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nx.w_got = 1'b1;
            nx.wdata = s_axi_wdata;
            nx.wstrb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got) begin
            nx.aw_got = 1'b0;
            nx.w_got = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = icx_pkg::RESP_OKAY;
            unique case (st.aw_addr)
                icx_pkg::REG_CTRL: begin
                    if (st.wstrb[0]) begin
                        nx.ext_en = st.wdata[icx_pkg::CTRL_EXT_EN_BIT];
                    end
                end
                icx_pkg::REG_STATUS, icx_pkg::REG_CALL_COUNT,
                icx_pkg::REG_CLEAR_COUNT: begin
                    nx.bresp = icx_pkg::RESP_OKAY;
                end
                default: begin
                    nx.bresp = icx_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end

        // register bus: read side
        if (s_axi_arvalid && s_axi_arready) begin
            nx.rvalid = 1'b1;
            nx.rresp = icx_pkg::RESP_OKAY;
            nx.rdata = 32'h00000000;
            unique case (s_axi_araddr)
                icx_pkg::REG_CTRL: begin
                    nx.rdata[icx_pkg::CTRL_EXT_EN_BIT] = st.ext_en;
                end
                icx_pkg::REG_STATUS: begin
                    nx.rdata[icx_pkg::STAT_NOP_BIT] = st.nop_cycle;
                    nx.rdata[icx_pkg::STAT_LAST_CALL_BIT] = st.last_call;
                    nx.rdata[icx_pkg::STAT_LAST_CLEAR_BIT] = st.last_clear;
                end
                icx_pkg::REG_CALL_COUNT: begin
                    nx.rdata[15:0] = st.call_count;
                end
                icx_pkg::REG_CLEAR_COUNT: begin
                    nx.rdata[15:0] = st.clear_count;
                end
                default: begin
                    nx.rresp = icx_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.phase <= icx_pkg::PH_Q1;
            st.op <= icx_pkg::OP_NONE;
            st.ext_en <= icx_pkg::CTRL_EXT_EN_RESET;
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign exec_nop = st.nop_cycle;
    assign quarter_phase = st.phase;
    assign stack_push = st.push;
    assign pc_load = st.pcload;
    assign file_write = st.fwr;
    assign zero_set = st.zero_set;
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_call_decode: assert property (call_take |=> st.op == icx_pkg::OP_CALL)
        else $error("call opcode not decoded");
    a_call_push_addr: assert property (call_take |-> ##3 (stack_push.valid
        && stack_push.addr == 21'($past(pc_current, 3) + icx_pkg::PC_STEP)))
        else $error("return address push wrong");
    a_call_pc_load: assert property (call_take |-> ##4 (pc_load.valid
        && !stack_push.valid && pc_load.pc == {$past(pc_upper_latch),
        $past(pc_high_latch), $past(working_register, 3)}))
        else $error("pc load wrong");
    a_call_nop_cycle: assert property (call_take |-> ##4 exec_nop [*4] ##1 !exec_nop)
        else $error("call second cycle not four quarters of nop");
    a_call_no_flags: assert property (call_take |=> (!zero_set && !file_write.valid) [*7])
        else $error("call touched flags or file");
    a_push_phase: assert property (stack_push.valid |-> $past(st.phase) == icx_pkg::PH_Q3)
        else $error("push outside third quarter");
    a_clr_write_zero: assert property (clr_take |-> ##4 (file_write.valid
        && file_write.data == icx_pkg::CLEAR_VALUE && zero_set))
        else $error("clear did not write zero with zero flag");
    a_clr_bank_sel: assert property ((clr_take && instr_word[8]) |-> ##4
        (file_write.addr == {$past(bank_select_register, 3), $past(instr_word[7:0], 4)}))
        else $error("bank select address wrong");
    a_clr_indexed: assert property ((clr_take && !instr_word[8] && st.ext_en
        && instr_word[7:0] <= icx_pkg::IDX_OFFSET_LIMIT) |-> ##4
        (file_write.addr == 14'($past(index_base, 3) + {6'h00, $past(instr_word[7:0], 4)})))
        else $error("indexed offset address wrong");
    a_clr_one_cycle: assert property (clr_take |=> (!file_write.valid && !exec_nop) [*3]
        ##1 (file_write.valid && !exec_nop))
        else $error("clear not within one instruction cycle");

endmodule : icx_exec

// ### icx_pkg.sv
// constants and types for the indirect call / register clear execution block
package icx_pkg;

    // ------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------
    localparam logic [15:0] OPC_CALL_VIA_WORKING_REGISTER = 16'h0014;
    localparam logic [6:0] OPC_CLEAR_FILE_HI = 7'h35;
    localparam int CLR_ACCESS_BIT = 8;
    localparam logic [7:0] IDX_OFFSET_LIMIT = 8'h5F;
    localparam logic [5:0] ACCESS_LOW_BANK = 6'h00;
    localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3F;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CALL_COUNT = 8'h08;
    localparam logic [7:0] REG_CLEAR_COUNT = 8'h0C;
    localparam int CTRL_EXT_EN_BIT = 0;
    localparam logic CTRL_EXT_EN_RESET = 1'b0;
    localparam int STAT_NOP_BIT = 0;
    localparam int STAT_LAST_CALL_BIT = 1;
    localparam int STAT_LAST_CLEAR_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } icx_phase_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_CALL = 3'b010,
        OP_CLEAR = 3'b100
    } icx_op_t;

    typedef struct packed {
        logic valid;
        logic [20:0] addr;
    } icx_push_t;

    typedef struct packed {
        logic valid;
        logic [20:0] pc;
    } icx_pcload_t;

    typedef struct packed {
        logic valid;
        logic [13:0] addr;
        logic [7:0] data;
    } icx_fwr_t;

    typedef struct packed {
        icx_phase_t phase;
        icx_op_t op;
        logic nop_cycle;
        logic [7:0] operand;
        logic access_sel;
        logic [20:0] pc_cap;
        logic [7:0] working_register_cap;
        logic [13:0] clr_addr;
        logic ext_en;
        logic last_call;
        logic last_clear;
        logic [15:0] call_count;
        logic [15:0] clear_count;
        icx_push_t push;
        icx_pcload_t pcload;
        icx_fwr_t fwr;
        logic zero_set;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } icx_state_t;

endpackage : icx_pkg

// ### icx_partner.sv
// behavioural program counter, return stack and data register file
`timescale 1ns/100ps
module icx_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire icx_pkg::icx_push_t stack_push,
    input wire icx_pkg::icx_pcload_t pc_load,
    input wire icx_pkg::icx_fwr_t file_write,
    input wire logic zero_set,
    input wire logic exec_nop,
    output logic [20:0] pc_current
);
    logic [20:0] stack_mem [0:30];
    logic [4:0] sp;
    logic [7:0] data_mem [0:16383];
    logic zero_flag;
    int cyc, push_cnt, load_cnt, nop_cnt, zero_mis, push_cyc, load_cyc, fwr_cyc;
    logic [13:0] fwr_q [$];

    // non-zero fill so that a clear is visible
    initial begin
        for (int i = 0; i < 16384; i++) begin
            data_mem[i] = 8'hA5;
        end
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (!aresetn) begin
            pc_current <= 21'h001230;
            sp <= 5'h00;
            zero_flag <= 1'b0;
        end else begin
            if (stack_push.valid) begin
                stack_mem[sp] <= stack_push.addr;
                sp <= sp + 5'h01;
                push_cnt <= push_cnt + 1;
                push_cyc <= cyc;
            end
            if (pc_load.valid) begin
                pc_current <= pc_load.pc;
                load_cnt <= load_cnt + 1;
                load_cyc <= cyc;
            end
            if (file_write.valid) begin
                data_mem[file_write.addr] <= file_write.data;
                fwr_q.push_back(file_write.addr);
                fwr_cyc <= cyc;
            end
            if (zero_set) begin
                zero_flag <= 1'b1;
            end
            if (zero_set !== file_write.valid) begin
                zero_mis <= zero_mis + 1;
            end
            if (exec_nop) begin
                nop_cnt <= nop_cnt + 1;
            end
        end
    end
endmodule : icx_partner

// ### testbench.sv
// self-checking bench for the indirect call / register clear block
`timescale 1ns/100ps
module testbench;
    logic aclk = 1'b0, aresetn, instr_valid, exec_nop, zero_set;
    logic [15:0] instr_word;
    logic [20:0] pc_current;
    logic [7:0] working_register, pc_high_latch, s_axi_awaddr, s_axi_araddr;
    logic [4:0] pc_upper_latch;
    logic [5:0] bank_select_register;
    logic [13:0] index_base;
    icx_pkg::icx_phase_t quarter_phase;
    icx_pkg::icx_push_t stack_push;
    icx_pkg::icx_pcload_t pc_load;
    icx_pkg::icx_fwr_t file_write;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total = 0, checks_done = 0, take_cyc, t0;
    logic [15:0] cw [7] = '{16'h6B34, 16'h6A5F, 16'h6A60, 16'h6A5F, 16'h6A10, 16'h6AFF, 16'h6B00};
    logic [5:0] cb [7] = '{6'h05, 6'h05, 6'h05, 6'h05, 6'h05, 6'h05, 6'h3F};
    logic [13:0] ci [7] = '{14'h0000, 14'h0000, 14'h0000, 14'h0200, 14'h3FF8, 14'h3FF8, 14'h0000};
    logic [13:0] ce [7] = '{14'h0534, 14'h005F, 14'h3F60, 14'h025F, 14'h0008, 14'h3FFF, 14'h3F00};

    always #4 aclk = ~aclk;

    icx_exec dut (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_current(pc_current), .working_register(working_register),
        .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
        .bank_select_register(bank_select_register), .index_base(index_base),
        .exec_nop(exec_nop), .quarter_phase(quarter_phase), .stack_push(stack_push),
        .pc_load(pc_load), .file_write(file_write), .zero_set(zero_set),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    icx_partner pc_i (.aclk(aclk), .aresetn(aresetn), .stack_push(stack_push),
        .pc_load(pc_load), .file_write(file_write), .zero_set(zero_set),
        .exec_nop(exec_nop), .pc_current(pc_current));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // drive a word for the coming Q1; returns at the edge that takes it
    task automatic issue(input logic [15:0] w, input logic [5:0] b, input logic [13:0] ib);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (quarter_phase !== icx_pkg::PH_Q4 && n < 20);
        chk(quarter_phase, icx_pkg::PH_Q4);
        instr_valid <= 1'b1;
        instr_word <= w;
        bank_select_register <= b;
        index_base <= ib;
        @(posedge aclk);
        take_cyc = pc_i.cyc;
        instr_valid <= 1'b0;
    endtask : issue

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        r = 2'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        r = 2'h1;
        d = 32'hFFFFFFFF;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #24000;
        err_total++;
        summarize();
    end

    initial begin
        {aresetn, instr_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} <= '0;
        {instr_word, working_register, pc_high_latch, pc_upper_latch} <= '0;
        {bank_select_register, index_base, s_axi_wdata} <= '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(icx_pkg::REG_CTRL, rd, rsp);
        chk(rd, 32'h0);
        chk(rsp, icx_pkg::RESP_OKAY);
        axi_rd(8'h10, rd, rsp);
        chk(rsp, icx_pkg::RESP_SLVERR);
        working_register <= 8'h06;
        pc_high_latch <= 8'h10;
        pc_upper_latch <= 5'h00;
        issue(16'h0014, 6'h05, 14'h0);
        t0 = take_cyc;
        issue(16'h6A12, 6'h05, 14'h0);
        issue(16'h0015, 6'h05, 14'h0);
        repeat (8) @(posedge aclk);
        chk(pc_i.push_cnt, 1);
        chk(pc_i.stack_mem[0], 32'h001232);
        chk(pc_i.push_cyc - t0, 3);
        chk(pc_i.load_cnt, 1);
        chk(pc_current, 32'h001006);
        chk(pc_i.load_cyc - t0, 4);
        chk(pc_i.nop_cnt, 4);
        chk(pc_i.fwr_q.size(), 0);
        chk(pc_i.zero_flag, 1'b0);
        for (int i = 0; i < 7; i++) begin
            if (i == 3) begin
                axi_wr(icx_pkg::REG_CTRL, 32'h1, rsp);
                chk(rsp, icx_pkg::RESP_OKAY);
            end
            issue(cw[i], cb[i], ci[i]);
        end
        repeat (8) @(posedge aclk);
        chk(pc_i.fwr_cyc - take_cyc, 4);
        chk(pc_i.fwr_q.size(), 7);
        for (int i = 0; i < 7; i++) begin
            chk(pc_i.fwr_q[i], ce[i]);
            chk(pc_i.data_mem[ce[i]], 8'h00);
        end
        chk(pc_i.zero_flag, 1'b1);
        chk(pc_i.zero_mis, 0);
        axi_rd(icx_pkg::REG_CLEAR_COUNT, rd, rsp);
        chk(rd, 32'h7);
        axi_rd(icx_pkg::REG_CALL_COUNT, rd, rsp);
        chk(rd, 32'h1);
        axi_rd(icx_pkg::REG_CTRL, rd, rsp);
        chk(rd, 32'h1);
        axi_rd(icx_pkg::REG_STATUS, rd, rsp);
        chk(rd, 32'h4);
        axi_wr(8'h20, 32'h1, rsp);
        chk(rsp, icx_pkg::RESP_SLVERR);
        summarize();
    end
endmodule : testbench
